// ### hdl/ccc_clock_conditioner.sv
// Clock conditioner: three slots of global buffer, delayed buffer or
// synthesizer, two core outputs, and a serial dynamic configuration path.
// Assumes clocks and serial pins are sampled by i_sys_clk.
// Operation
// [RULE1] Three buffers, or one synthesizer, per instance
// [RULE2] Spare global outputs usable as plain buffers
// [RULE3] Buffer allowed in any of three slots
// [RULE4] Synthesizer uses first input, drives first output
// [RULE5] Synthesizer may drive two core outputs
// [RULE6] Used core output blocks its matching global
// [RULE7] Source: three single, two differential, core
// [RULE8] Plain buffers pass clock straight through
// [RULE9] Delayed buffer adds programmable delay, no synthesizer
// [RULE10] Core, three phases, seven delays, five dividers
// [RULE11] Static bits or dynamic shift register configure
// [RULE12] Core logic shifts register in serially
// [RULE13] Dynamic load changes ratios and delays live
// [RULE14] Routed clocks come from logic, not pads
// [RULE15] Own shift clock; applies after complete load
`timescale 1ns/1ps
`default_nettype none
module ccc_clock_conditioner
   import ccc_pkg::*;
(
   input  wire logic                         i_sys_clk,
   input  wire logic                         i_rst,
   input  wire logic [ccc_pkg::NUM_SE-1:0]   i_se_clk,
   input  wire logic [ccc_pkg::NUM_DIFF-1:0] i_diff_p,
   input  wire logic [ccc_pkg::NUM_DIFF-1:0] i_diff_n,
   input  wire logic                         i_core_clk,
   input  wire logic [ccc_pkg::CFG_W-1:0]    i_static_cfg,
   input  wire logic                         i_dyn_sel,
   input  wire logic                         i_cfg_sclk,
   input  wire logic                         i_cfg_sdin,
   input  wire logic                         i_cfg_shift,
   input  wire logic                         i_cfg_update,
   output logic                              o_first_global_output,
   output logic                              o_second_global_output,
   output logic                              o_third_global_output,
   output logic                              o_second_core_output,
   output logic                              o_third_core_output,
   output logic                              o_cfg_sdout,
   output logic                              o_cfg_loaded,
   output logic                              o_cfg_conflict
);
   import ccc_pkg::*;

   function automatic logic [DLY_W-1:0] fld5(input logic [CFG_W-1:0] c,
                                             input int p);
      fld5 = c[p +: DLY_W];
   endfunction

   function automatic logic pick_src(input logic [SRC_W-1:0] s,
                                     input logic [NUM_SE-1:0] se,
                                     input logic [NUM_DIFF-1:0] dp,
                                     input logic [NUM_DIFF-1:0] dn,
                                     input logic core);
      unique case (s)
         SRC_SE0:   pick_src = se[0];
         SRC_SE1:   pick_src = se[1];
         SRC_SE2:   pick_src = se[2];
         SRC_DIFF0: pick_src = dp[0] & ~dn[0];
         SRC_DIFF1: pick_src = dp[1] & ~dn[1];
         SRC_CORE:  pick_src = core;
         default:   pick_src = 1'b0;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // Serial configuration port
   // -----------------------------------------------------------------
   logic [3:0]       s1_reg, s2_reg, s1_next, s2_next;
   logic             sclk_d_reg, sclk_d_next, sclk_rise;
   logic [CFG_W-1:0] sh_reg, sh_next, dyn_reg, dyn_next;
   logic [CFG_W-1:0] stat_reg, stat_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             strap_reg, strap_next;

   assign sclk_rise = s2_reg[0] & ~sclk_d_reg; // see [RULE15]

   always_comb begin
      s1_next     = {i_cfg_update, i_cfg_shift, i_cfg_sdin, i_cfg_sclk};
      s2_next     = s1_reg;
      sclk_d_next = s2_reg[0];
      sh_next     = sh_reg;
      cnt_next    = cnt_reg;
      dyn_next    = dyn_reg;
      stat_next   = stat_reg;
      strap_next  = 1'b1;
      if (!strap_reg) begin
         stat_next = i_static_cfg; // see [RULE11]
         dyn_next  = i_static_cfg;
      end
      if (sclk_rise && s2_reg[2]) begin
         sh_next = {s2_reg[1], sh_reg[CFG_W-1:1]}; // see [RULE12]
         if (cnt_reg != CFG_BITS) begin
            cnt_next = cnt_reg + 7'h01;
         end
      end else if (sclk_rise && s2_reg[3]) begin
         if (cnt_reg == CFG_BITS) begin
            dyn_next = sh_reg; // see [RULE13] [RULE15]
         end
         cnt_next = '0;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_reg     <= '0;
         s2_reg     <= '0;
         sclk_d_reg <= 1'b0;
         sh_reg     <= '0;
         cnt_reg    <= '0;
         dyn_reg    <= '0;
         stat_reg   <= '0;
         strap_reg  <= 1'b0;
      end else begin
         s1_reg     <= s1_next;
         s2_reg     <= s2_next;
         sclk_d_reg <= sclk_d_next;
         sh_reg     <= sh_next;
         cnt_reg    <= cnt_next;
         dyn_reg    <= dyn_next;
         stat_reg   <= stat_next;
         strap_reg  <= strap_next;
      end
   end

   logic [CFG_W-1:0] cfg;
   assign cfg          = i_dyn_sel ? dyn_reg : stat_reg; // see [RULE11]
   assign o_cfg_sdout  = sh_reg[0];
   assign o_cfg_loaded = (cnt_reg == CFG_BITS);

   // -----------------------------------------------------------------
   // Source selection and delays
   // -----------------------------------------------------------------
   ccc_mode_e        mode [NUM_SLOTS];
   logic             src [NUM_SLOTS];
   logic             dly_in [NUM_DLY];
   logic [DLY_W-1:0] dly_sel [NUM_DLY];
   logic             dly_out [NUM_DLY];
   logic             syn_on, yb_en, yc_en;
   logic [NUM_SLOTS-1:0] syn_clk;
   logic                 fb_src;

   assign syn_on = (mode[0] == SLOT_SYNTH); // see [RULE4]
   assign yb_en  = syn_on & cfg[F_YB_EN];   // see [RULE5]
   assign yc_en  = syn_on & cfg[F_YC_EN];

   always_comb begin
      for (int k = 0; k < NUM_SLOTS; k++) begin
         mode[k] = ccc_mode_e'(cfg[k*SLOT_W+F_MODE +: MODE_W]);
         src[k]  = pick_src(cfg[k*SLOT_W+F_SRC +: SRC_W], i_se_clk,
                            i_diff_p, i_diff_n, i_core_clk); // see [RULE7]
         dly_in[k]  = (mode[k] == SLOT_SYNTH) ? syn_clk[k] : src[k];
         dly_sel[k] = fld5(cfg, k*SLOT_W+F_DLY); // see [RULE9]
      end
      dly_in[DLY_YB]   = syn_clk[1];
      dly_sel[DLY_YB]  = fld5(cfg, F_YB_DLY);
      dly_in[DLY_YC]   = syn_clk[2];
      dly_sel[DLY_YC]  = fld5(cfg, F_YC_DLY);
      dly_in[DLY_FB]   = fb_src;
      dly_sel[DLY_FB]  = fld5(cfg, F_FB_DLY);
      dly_in[DLY_FIX]  = src[0]; // see [RULE4]
      dly_sel[DLY_FIX] = FIXED_DLY_TAPS;
   end

   for (genvar g = 0; g < NUM_DLY; g++) begin : g_dly // see [RULE10]
      ccc_delay_line u_dly (
         .i_sys_clk (i_sys_clk),
         .i_rst     (i_rst),
         .i_clk_in  (dly_in[g]),
         .i_sel     (dly_sel[g]),
         .o_clk_out (dly_out[g])
      );
   end

   // -----------------------------------------------------------------
   // Synthesizer: pre divider, feedback-timed oscillator, output dividers
   // -----------------------------------------------------------------
   logic [DIV_W-1:0]   dcnt_reg [NUM_DIV];
   logic [DIV_W-1:0]   dcnt_next [NUM_DIV];
   logic [NUM_DIV-1:0] dq_reg, dq_next;
   logic               ref_d_reg, ref_d_next, fb_d_reg, fb_d_next;
   logic               ref_rise, fb_rise, vco_rise;

   assign ref_rise     = dly_out[DLY_FIX] & ~ref_d_reg;
   assign fb_src       = dq_reg[DIV_PRE];
   assign fb_rise      = dly_out[DLY_FB] & ~fb_d_reg;
   assign vco_rise     = ~dq_reg[DIV_FB] & (dcnt_reg[DIV_FB] ==
                         fld5(cfg, F_DIV + DIV_FB*DIV_W));

   always_comb begin
      ref_d_next = dly_out[DLY_FIX];
      fb_d_next  = dly_out[DLY_FB];
      for (int d = 0; d < NUM_DIV; d++) begin
         dcnt_next[d] = dcnt_reg[d];
         dq_next[d]   = dq_reg[d];
      end
      if (syn_on) begin
         if (ref_rise) begin
            dcnt_next[DIV_PRE] = dcnt_reg[DIV_PRE] + 5'h01;
            if (dcnt_reg[DIV_PRE] == fld5(cfg, F_DIV)) begin
               dcnt_next[DIV_PRE] = '0;
               dq_next[DIV_PRE]   = ~dq_reg[DIV_PRE];
            end
         end
         if (fb_rise) begin
            dcnt_next[DIV_FB] = '0;
            dq_next[DIV_FB]   = 1'b1;
         end else begin
            dcnt_next[DIV_FB] = dcnt_reg[DIV_FB] + 5'h01;
            if (dcnt_reg[DIV_FB] == fld5(cfg, F_DIV + DIV_FB*DIV_W)) begin
               dcnt_next[DIV_FB] = '0;
               dq_next[DIV_FB]   = ~dq_reg[DIV_FB];
            end
         end
         for (int d = 1; d < DIV_FB; d++) begin
            if (vco_rise) begin
               dcnt_next[d] = dcnt_reg[d] + 5'h01;
               if (dcnt_reg[d] == fld5(cfg, F_DIV + d*DIV_W)) begin
                  dcnt_next[d] = '0;
                  dq_next[d]   = ~dq_reg[d];
               end
            end
         end
      end else begin
         for (int d = 0; d < NUM_DIV; d++) begin
            dcnt_next[d] = '0;
            dq_next[d]   = 1'b0;
         end
      end
      for (int k = 0; k < NUM_SLOTS; k++) begin
         syn_clk[k] = dq_reg[k+1] ^ cfg[F_PHASE+k]; // see [RULE10]
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int d = 0; d < NUM_DIV; d++) begin
            dcnt_reg[d] <= '0;
         end
         dq_reg    <= '0;
         ref_d_reg <= 1'b0;
         fb_d_reg  <= 1'b0;
      end else begin
         dcnt_reg  <= dcnt_next;
         dq_reg    <= dq_next;
         ref_d_reg <= ref_d_next;
         fb_d_reg  <= fb_d_next;
      end
   end

   // -----------------------------------------------------------------
   // Output slots
   // -----------------------------------------------------------------
   logic [NUM_SLOTS-1:0] gl_reg, gl_next, bad;
   logic                 yb_reg, yc_reg, yb_next, yc_next;
   logic                 conf_reg, conf_next;

   always_comb begin
      for (int k = 0; k < NUM_SLOTS; k++) begin
         bad[k] = 1'b0;
         if (mode[k] == SLOT_SYNTH && !syn_on) begin
            bad[k] = 1'b1; // see [RULE1] [RULE4]
         end
      end
      if ((yb_en && mode[1] != SLOT_SYNTH && mode[1] != SLOT_OFF) ||
          (yc_en && mode[2] != SLOT_SYNTH && mode[2] != SLOT_OFF)) begin
         bad[1] = bad[1] | (yb_en & mode[1] != SLOT_SYNTH); // see [RULE6]
         bad[2] = bad[2] | (yc_en & mode[2] != SLOT_SYNTH);
      end
      for (int k = 0; k < NUM_SLOTS; k++) begin
         unique case (mode[k]) // see [RULE2] [RULE3]
            SLOT_OFF:    gl_next[k] = 1'b0;
            SLOT_BUF:    gl_next[k] = src[k]; // see [RULE8] [RULE14]
            SLOT_DLYBUF: gl_next[k] = dly_out[k]; // see [RULE9]
            SLOT_SYNTH:  gl_next[k] = dly_out[k];
         endcase
         if (bad[k]) begin
            gl_next[k] = 1'b0;
         end
      end
      yb_next   = yb_en & dly_out[DLY_YB]; // see [RULE5]
      yc_next   = yc_en & dly_out[DLY_YC];
      conf_next = |bad;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         gl_reg   <= '0;
         yb_reg   <= 1'b0;
         yc_reg   <= 1'b0;
         conf_reg <= 1'b0;
      end else begin
         gl_reg   <= gl_next;
         yb_reg   <= yb_next;
         yc_reg   <= yc_next;
         conf_reg <= conf_next;
      end
   end

   assign o_first_global_output  = gl_reg[0];
   assign o_second_global_output = gl_reg[1];
   assign o_third_global_output  = gl_reg[2];
   assign o_second_core_output   = yb_reg;
   assign o_third_core_output    = yc_reg;
   assign o_cfg_conflict         = conf_reg;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_full_load;
      o_cfg_loaded && sclk_rise && s2_reg[3] && !s2_reg[2];
   endsequence

   a_buf_pass: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE8]
      (mode[0] == SLOT_BUF) |=> o_first_global_output == $past(src[0]))
      else $error("plain buffer does not pass its source");
   a_src_core: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE7]
      (cfg[F_SRC +: SRC_W] == SRC_CORE) |-> src[0] == i_core_clk)
      else $error("core source not selected");
   a_load_apply: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE15]
      s_full_load |=> dyn_reg == $past(sh_reg))
      else $error("complete load not applied");
   a_partial_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE15]
      strap_reg && !o_cfg_loaded |=> $stable(dyn_reg))
      else $error("partial load changed configuration");
   a_shift_in: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE12]
      sclk_rise && s2_reg[2] |=> sh_reg[CFG_W-1] == $past(s2_reg[1]))
      else $error("serial bit not shifted in");
   a_yb_block: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE6]
      yb_en && mode[1] == SLOT_BUF |=> !o_second_global_output && o_cfg_conflict)
      else $error("second global reused while core output active");
   a_synth_need: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE4]
      !syn_on |=> dq_reg == '0 && !o_second_core_output)
      else $error("synthesizer runs without first slot");
   a_off_low: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [RULE3]
      (mode[2] == SLOT_OFF) |=> !o_third_global_output)
      else $error("unused slot drives its global");
endmodule
`default_nettype wire

// ### hdl/ccc_pkg.sv
// Constants, configuration layout and modes of the clock conditioner.
// Assumes all clock-like inputs are sampled by the single system clock.
package ccc_pkg;
   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int NUM_SLOTS   = 3;
   localparam int NUM_SE      = 3;
   localparam int NUM_DIFF    = 2;
   localparam int NUM_DIV     = 5;
   localparam int NUM_PDLY    = 6;
   localparam int NUM_DLY     = 7;
   localparam int DLY_W       = 5;
   localparam int DLY_DEPTH   = 32;
   localparam int DIV_W       = 5;
   localparam int SRC_W       = 3;
   localparam int MODE_W      = 2;
   localparam int SLOT_W      = 10;
   localparam int CFG_W       = 75;
   localparam int CNT_W       = 7;

   // -----------------------------------------------------------------
   // Field positions in the configuration word
   // -----------------------------------------------------------------
   localparam int F_MODE      = 0;
   localparam int F_SRC       = 2;
   localparam int F_DLY       = 5;
   localparam int F_DIV       = 30;
   localparam int F_YB_EN     = 55;
   localparam int F_YC_EN     = 56;
   localparam int F_YB_DLY    = 57;
   localparam int F_YC_DLY    = 62;
   localparam int F_FB_DLY    = 67;
   localparam int F_PHASE     = 72;

   // -----------------------------------------------------------------
   // Indices of dividers and delays
   // -----------------------------------------------------------------
   localparam int DIV_PRE     = 0;
   localparam int DIV_FB      = 4;
   localparam int DLY_YB      = 3;
   localparam int DLY_YC      = 4;
   localparam int DLY_FB      = 5;
   localparam int DLY_FIX     = 6;
   localparam logic [DLY_W-1:0] FIXED_DLY_TAPS = 5'h11;
   localparam logic [CNT_W-1:0] CFG_BITS       = 7'h4B;

   // -----------------------------------------------------------------
   // Encodings
   // -----------------------------------------------------------------
   typedef enum logic [MODE_W-1:0] {
      SLOT_OFF    = 2'h0,
      SLOT_BUF    = 2'h1,
      SLOT_DLYBUF = 2'h2,
      SLOT_SYNTH  = 2'h3
   } ccc_mode_e;

   localparam logic [SRC_W-1:0] SRC_SE0   = 3'h0;
   localparam logic [SRC_W-1:0] SRC_SE1   = 3'h1;
   localparam logic [SRC_W-1:0] SRC_SE2   = 3'h2;
   localparam logic [SRC_W-1:0] SRC_DIFF0 = 3'h3;
   localparam logic [SRC_W-1:0] SRC_DIFF1 = 3'h4;
   localparam logic [SRC_W-1:0] SRC_CORE  = 3'h5;
endpackage

// ### hdl/ccc_delay_line.sv
// Programmable tap delay of one clock signal, in system clock steps.
// Assumes the select is stable while a phase-exact output is needed.
`timescale 1ns/1ps
`default_nettype none
module ccc_delay_line
   import ccc_pkg::*;
(
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_rst,
   input  wire logic                     i_clk_in,
   input  wire logic [ccc_pkg::DLY_W-1:0] i_sel,
   output logic                          o_clk_out
);
   import ccc_pkg::*;

   logic [DLY_DEPTH-1:0] tap_reg;
   logic [DLY_DEPTH-1:0] tap_next;
   logic                 out_reg;
   logic                 out_next;

   // -----------------------------------------------------------------
   // Tap chain
   // -----------------------------------------------------------------
   always_comb begin
      tap_next = {tap_reg[DLY_DEPTH-2:0], i_clk_in};
      out_next = tap_reg[i_sel];
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tap_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         tap_reg <= tap_next;
         out_reg <= out_next;
      end
   end

   assign o_clk_out = out_reg;

   a_delay_taps: assert property ( // see [RULE9]
      @(posedge i_sys_clk) disable iff (i_rst)
      !$past(i_rst, 2) && $past(i_sel) == '0 |-> out_reg == $past(i_clk_in, 2))
      else $error("delay output does not match selected tap");
endmodule
`default_nettype wire

// ### testbench/ccc_cfg_loader.sv
// Fabric-side model that loads the serial configuration register.
// Assumes the bench calls load() and that i_sys_clk runs throughout.
`timescale 1ns/1ps
`default_nettype none
module ccc_cfg_loader
   import ccc_pkg::*;
(
   input  wire logic i_sys_clk,
   output var  logic o_cfg_sclk,
   output var  logic o_cfg_sdin,
   output var  logic o_cfg_shift,
   output var  logic o_cfg_update
);
   import ccc_pkg::*;

   initial begin
      o_cfg_sclk   = 1'h0;
      o_cfg_sdin   = 1'h0;
      o_cfg_shift  = 1'h0;
      o_cfg_update = 1'h0;
   end

   // -----------------------------------------------------------------
   // Serial clock pulse, three cycles a phase, for shift bits and for the update clock
   // -----------------------------------------------------------------
   task automatic pulse();
      repeat (3) @(posedge i_sys_clk);
      o_cfg_sclk <= 1'h1;
      repeat (3) @(posedge i_sys_clk);
      o_cfg_sclk <= 1'h0;
      repeat (3) @(posedge i_sys_clk);
   endtask

   // -----------------------------------------------------------------
   // Shift n bits of w, bit 0 first, then an optional update clock
   // -----------------------------------------------------------------
   task automatic load(input logic [ccc_pkg::CFG_W-1:0] w, input int n,
                       input logic upd);
      for (int i = 0; i < n; i++) begin
         @(posedge i_sys_clk);
         o_cfg_sdin  <= w[i];
         o_cfg_shift <= 1'h1;
         pulse();
      end
      @(posedge i_sys_clk);
      o_cfg_shift <= 1'h0;
      o_cfg_sdin  <= ~o_cfg_sdin;
      if (upd) begin
         o_cfg_update <= 1'h1;
         pulse();
         @(posedge i_sys_clk);
         o_cfg_update <= 1'h0;
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/test_ccc_clock_conditioner.sv
// Self-checking bench of the clock conditioner.
// Assumes the loader model sits on the serial configuration port.
`timescale 1ns/1ps
`default_nettype none
module test_ccc_clock_conditioner;
   import ccc_pkg::*;
   logic                sys_clk    = 1'h0;
   logic                rst        = 1'h1;
   logic [NUM_SE-1:0]   se_clk     = '0;
   logic [NUM_DIFF-1:0] diff_p     = '0;
   logic [NUM_DIFF-1:0] diff_n     = '1;
   logic                core_clk   = 1'h0;
   logic [CFG_W-1:0]    static_cfg = '0;
   logic                dyn_sel    = 1'h0;
   wire  logic          sclk, sdin, shift, update;
   wire  logic          yb, yc, sdout, loaded, conflict;
   wire  logic [2:0]    gl;
   int                  fails      = 0;
   int                  compares   = 0;
   int                  cyc        = 0;

   ccc_clock_conditioner u_dut (
      .i_sys_clk(sys_clk), .i_rst(rst), .i_se_clk(se_clk),
      .i_diff_p(diff_p), .i_diff_n(diff_n), .i_core_clk(core_clk),
      .i_static_cfg(static_cfg), .i_dyn_sel(dyn_sel),
      .i_cfg_sclk(sclk), .i_cfg_sdin(sdin), .i_cfg_shift(shift),
      .i_cfg_update(update), .o_first_global_output(gl[0]),
      .o_second_global_output(gl[1]), .o_third_global_output(gl[2]),
      .o_second_core_output(yb), .o_third_core_output(yc),
      .o_cfg_sdout(sdout), .o_cfg_loaded(loaded),
      .o_cfg_conflict(conflict)
   );
   ccc_cfg_loader u_loader (
      .i_sys_clk(sys_clk), .o_cfg_sclk(sclk), .o_cfg_sdin(sdin),
      .o_cfg_shift(shift), .o_cfg_update(update)
   );

   // -----------------------------------------------------------------
   // Clock, timeout and reporting
   // -----------------------------------------------------------------
   always #4 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("Counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [CFG_W-1:0] slot(input logic [CFG_W-1:0] c,
      input int k, input logic [MODE_W-1:0] m, input logic [SRC_W-1:0] s,
      input logic [DLY_W-1:0] d);
      logic [CFG_W-1:0] r;
      r = c;
      r[SLOT_W*k+F_MODE +: MODE_W] = m;
      r[SLOT_W*k+F_SRC +: SRC_W]   = s;
      r[SLOT_W*k+F_DLY +: DLY_W]   = d;
      return r;
   endfunction

   task automatic restart(input logic [CFG_W-1:0] c, input logic d);
      @(posedge sys_clk);
      rst        <= 1'h1;
      static_cfg <= c;
      dyn_sel    <= d;
      repeat (2) @(posedge sys_clk);
      #1 chk("globals in reset", 32'h0, {29'h0, gl});
      @(posedge sys_clk);
      rst <= 1'h0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic drive(input int s, input logic v);
      if (s < 3) begin
         se_clk[s] <= v;
      end else if (s < 5) begin
         diff_p[s-3] <= v;
         diff_n[s-3] <= ~v;
      end else begin
         core_clk <= v;
      end
   endtask

   task automatic pass_chk(input int k, input int s, input logic e);
      @(posedge sys_clk);
      drive(s, 1'h1);
      #1 chk("global before edge", 32'h0, {31'h0, gl[k]});
      @(posedge sys_clk);
      #1 chk("global one cycle on", {31'h0, e}, {31'h0, gl[k]});
      @(posedge sys_clk);
      drive(s, 1'h0);
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic lat(input logic [DLY_W-1:0] d, output int n);
      restart(slot('0, 0, SLOT_DLYBUF, SRC_SE0, d), 1'h0);
      @(posedge sys_clk);
      se_clk[0] <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (gl[0] !== 1'h1 && n < 80);
      @(posedge sys_clk);
      se_clk[0] <= 1'h0;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_buffers();
      for (int k = 0; k < 3; k++) begin
         for (int s = 0; s < 6; s++) begin
            restart(slot('0, k, SLOT_BUF, s[SRC_W-1:0], '0), 1'h0);
            pass_chk(k, s, 1'h1);
            pass_chk((k + 1) % 3, s, 1'h0);
         end
      end
      $display("Test buffers done");
   endtask

   task automatic t_delay();
      int a;
      int b;
      lat(5'h00, a);
      lat(5'h1F, b);
      chk("delay floor", 32'h3, a);
      chk("delay span", 32'h1F, b - a);
      $display("Test delay done");
   endtask

   task automatic t_conflict();
      logic [CFG_W-1:0] c;
      c = slot('0, 0, SLOT_SYNTH, SRC_SE0, '0);
      c = slot(c, 1, SLOT_BUF, SRC_SE1, '0);
      c[F_YB_EN] = 1'h1;
      restart(c, 1'h0);
      chk("core B conflict", 32'h1, {31'h0, conflict});
      pass_chk(1, 1, 1'h0);
      restart(slot('0, 1, SLOT_SYNTH, SRC_SE0, '0), 1'h0);
      chk("synth conflict", 32'h1, {31'h0, conflict});
      restart(slot('0, 1, SLOT_BUF, SRC_SE1, '0), 1'h0);
      chk("no conflict", 32'h0, {31'h0, conflict});
      $display("Test conflict done");
   endtask

   task automatic t_synth();
      logic [CFG_W-1:0] c;
      logic             pa;
      logic             pb;
      int               na;
      int               nb;
      int               nc;
      c = slot('0, 0, SLOT_SYNTH, SRC_SE0, '0);
      c = slot(c, 1, SLOT_SYNTH, SRC_SE0, '0);
      c = slot(c, 2, SLOT_BUF, SRC_SE2, '0);
      c[F_YB_EN] = 1'h1;
      c[F_DIV +: 25] = {5{5'h01}};
      restart(c, 1'h0);
      chk("synth no conflict", 32'h0, {31'h0, conflict});
      pass_chk(2, 2, 1'h1);
      pa = gl[0];
      pb = yb;
      na = 0;
      nb = 0;
      nc = 0;
      for (int i = 0; i < 600; i++) begin
         @(posedge sys_clk);
         if (i % 4 == 0) begin
            se_clk[0] <= ~se_clk[0];
         end
         #1;
         na += (gl[0] !== pa);
         nb += (yb !== pb);
         nc += (yc !== 1'h0);
         pa = gl[0];
         pb = yb;
      end
      chk("synth global A moves", 32'h1, {31'h0, na > 2});
      chk("synth core B moves", 32'h1, {31'h0, nb > 2});
      chk("core C idle", 32'h0, nc);
      $display("Test synth done");
   endtask

   task automatic t_dynamic();
      logic [CFG_W-1:0] w;
      w = slot('0, 0, SLOT_BUF, SRC_SE1, '0);
      restart('0, 1'h1);
      u_loader.load(w, 74, 1'h0);
      repeat (6) @(posedge sys_clk);
      #1 chk("short frame loaded", 32'h0, {31'h0, loaded});
      u_loader.load(w, 0, 1'h1);
      repeat (6) @(posedge sys_clk);
      pass_chk(0, 1, 1'h0);
      u_loader.load(w, 75, 1'h0);
      repeat (6) @(posedge sys_clk);
      #1 chk("full frame loaded", 32'h1, {31'h0, loaded});
      chk("first bit at out", {31'h0, w[0]}, {31'h0, sdout});
      pass_chk(0, 1, 1'h0);
      u_loader.load(w, 0, 1'h1);
      repeat (6) @(posedge sys_clk);
      pass_chk(0, 1, 1'h1);
      @(posedge sys_clk);
      dyn_sel <= 1'h0;
      repeat (3) @(posedge sys_clk);
      pass_chk(0, 1, 1'h0);
      $display("Test dynamic done");
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      repeat (3) @(posedge sys_clk);
      t_buffers();
      t_delay();
      t_conflict();
      t_synth();
      t_dynamic();
      summarize();
   end
endmodule
`default_nettype wire
